// ==== logic/filter_if.sv ====
// filter_if: link between a channel and its input glitch filter
// assumes both ends share aclk and aresetn
interface filter_if (
  input wire logic aclk,
  input wire logic aresetn
);
  logic sample;
  logic tick;
  logic [timer_pkg::FV_W-1:0] fval;
  logic filt;

  modport chan_mp (output sample, output tick, output fval, input filt);
  modport filter_mp (input aclk, input aresetn, input sample, input tick, input fval,
                     output filt);
endinterface : filter_if

// ==== logic/glitch_filter.sv ====
// glitch_filter: validates a synchronised level after it holds fval filter ticks
// assumes sample is already synchronised and tick pulses once per four clocks
module glitch_filter (
  filter_if.filter_mp f
);
  logic [timer_pkg::FV_W-1:0] cnt_r;
  logic [timer_pkg::FV_W-1:0] cnt_nxt;
  logic last_r;
  logic filt_r;
  logic restart;

  assign cnt_nxt = cnt_r + 4'h1;
  // a change of state, or no pending change, keeps the counter at zero
  assign restart = (f.sample != last_r) || (f.sample == filt_r);
  assign f.filt = filt_r;

  always_ff @(posedge f.aclk) begin
    if (!f.aresetn) begin
      cnt_r <= 4'h0;
      last_r <= 1'b0;
      filt_r <= 1'b0;
    end else begin
      last_r <= f.sample;
      if (restart) begin
        cnt_r <= 4'h0;
      end else if (f.tick) begin
        cnt_r <= cnt_nxt;
        if (cnt_nxt == f.fval)
          filt_r <= f.sample;
      end
    end
  end
endmodule : glitch_filter

// ==== logic/timer_core.sv ====
// timer_core: shared 16-bit up counter with capture, compare and edge pwm channels
// assumes AXI4-Lite master on aclk; channel pins may be asynchronous, two-stage synchronised inside
// Summary of operation
// - capture: all special modes off, mode 00, edge nonzero
// - selected edge copies counter, sets flag, interrupt
// - capture is edge sensitive, edge bits pick polarity
// - value writes ignored while capturing
// - debug halt freezes counter, capture still works
// - unfiltered flag set third clock after edge
// - glitch filter only on channels zero to three
// - filter counter restarts on change, validates at value
// - pulses shorter than value times four dropped
// - zero filter value bypasses filter
// - filtered flag after four plus four times value
// - filter counter steps on clock divided by four
// - compare: special modes off, mode 01
// - compare match sets, clears or toggles output
// - toggle keeps old level until first match
// - match sets flag; edge 00 leaves pin undriven
// - edge pwm: special modes off, mode high bit
// - period final minus initial plus one; flag ends pulse
// - high-true: high at reload, low at match
// - low-true: low at reload, high at match
// - value zero gives 0%, above final 100%, no flag
// - value equal initial 0%, below initial 100%
// - one 16-bit counter shared by all channels
// - count initial to final, reload marks overflow
// - everything runs on the one system clock
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
module timer_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [timer_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [timer_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic debug_halt,
  input wire logic [timer_pkg::NCH-1:0] channel_pin_in,
  output logic [timer_pkg::NCH-1:0] channel_pin_out,
  output logic [timer_pkg::NCH-1:0] channel_pin_oe_n,
  output logic [timer_pkg::NCH-1:0] channel_irq
);
  localparam int NCH = timer_pkg::NCH;
  localparam int CW = timer_pkg::CW;

  // bus slave state
  logic [timer_pkg::AW-1:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // timer state
  logic [timer_pkg::CTRL_W-1:0] ctrl_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] initial_count_r;
  logic [CW-1:0] final_count_r;
  logic [timer_pkg::PSC_W-1:0] psc_r;
  logic [1:0] fdiv_r;

  logic [NCH-1:0] flags;
  logic [NCH-1:0][timer_pkg::CFG_W-1:0] cfgv;
  logic [NCH-1:0][CW-1:0] valv;

  // write decode
  wire do_wr = aw_have_r && w_have_r && !bvalid_r;
  wire [timer_pkg::AW-1:0] wa = {aw_addr_r[timer_pkg::AW-1:2], 2'h0};
  wire wr_hit = timer_pkg::reg_hit(aw_addr_r);
  wire [31:0] wr_old = timer_pkg::reg_read(aw_addr_r, ctrl_r, count_r, initial_count_r,
                                           final_count_r, flags, cfgv, valv);
  wire [31:0] wr_word = timer_pkg::wmerge(wr_old, w_data_r, w_strb_r);
  wire wr_ctrl = do_wr && (wa == timer_pkg::OFF_CTRL);
  wire wr_count = do_wr && (wa == timer_pkg::OFF_COUNT);
  wire wr_init = do_wr && (wa == timer_pkg::OFF_INIT);
  wire wr_final = do_wr && (wa == timer_pkg::OFF_FINAL);
  wire wr_flags = do_wr && (wa == timer_pkg::OFF_FLAGS);
  wire wr_chan = do_wr && (wa[timer_pkg::AW-1:6] == timer_pkg::CHAN_PAGE);
  wire [2:0] wr_idx = wa[5:timer_pkg::CHAN_SEL_LSB];
  wire wr_is_val = wa[timer_pkg::CHAN_VAL_BIT];
  // flags clear on written ones of the low lane only
  wire [NCH-1:0] flag_clr = (wr_flags && w_strb_r[0]) ? w_data_r[NCH-1:0] : '0;

  // read decode
  wire rd_take = arvalid && !rvalid_r;
  wire rd_hit = timer_pkg::reg_hit(araddr);
  wire [31:0] rd_word = timer_pkg::reg_read(araddr, ctrl_r, count_r, initial_count_r,
                                            final_count_r, flags, cfgv, valv);

  assign awready = !aw_have_r;
  assign wready = !w_have_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= timer_pkg::RESP_OKAY;
    end else begin
      if (awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= timer_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // shared counter and prescaler
  wire [timer_pkg::CTRL_PS_W-1:0] ps_sel = ctrl_r[timer_pkg::CTRL_PS_LSB +: timer_pkg::CTRL_PS_W];
  wire [timer_pkg::PSC_W-1:0] psc_top = 7'((8'h01 << ps_sel) - 8'h01);
  wire cas = ctrl_r[timer_pkg::CTRL_CAS];
  // debug halt freezes the count while capture keeps sampling it
  wire run = ctrl_r[timer_pkg::CTRL_EN] && !debug_halt;
  wire cnt_tick = run && (psc_r == psc_top);
  wire at_final = (count_r == final_count_r);
  wire overflow = cnt_tick && at_final;
  wire [CW-1:0] count_nxt = at_final ? initial_count_r : count_r + 16'h0001;
  wire filt_tick = (fdiv_r == timer_pkg::FILT_DIV_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= timer_pkg::CTRL_RST;
      initial_count_r <= timer_pkg::CNT_RST;
      final_count_r <= timer_pkg::FINAL_RST;
    end else begin
      if (wr_ctrl)
        ctrl_r <= wr_word[timer_pkg::CTRL_W-1:0];
      if (wr_init)
        initial_count_r <= wr_word[CW-1:0];
      if (wr_final)
        final_count_r <= wr_word[CW-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= timer_pkg::CNT_RST;
      psc_r <= 7'h00;
      fdiv_r <= 2'h0;
    end else begin
      fdiv_r <= fdiv_r + 2'h1;
      if (wr_count) begin
        // any write restarts the period from the initial count
        count_r <= initial_count_r;
        psc_r <= 7'h00;
      end else if (cnt_tick) begin
        count_r <= count_nxt;
        psc_r <= 7'h00;
      end else if (run) begin
        psc_r <= psc_r + 7'h01;
      end
    end
  end

  // channels
  for (genvar n = 0; n < NCH; n++) begin : g_chan
    logic [timer_pkg::CFG_W-1:0] cfg_r;
    logic [CW-1:0] val_r;
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic flag_r;
    logic out_r;
    logic filt_in;
    timer_pkg::mode_t mode;

    wire ela = cfg_r[timer_pkg::CFG_ELA];
    wire elb = cfg_r[timer_pkg::CFG_ELB];
    wire [timer_pkg::FV_W-1:0] fval = cfg_r[timer_pkg::CFG_FV_LSB +: timer_pkg::FV_W];
    wire sel = wr_chan && (int'(wr_idx) == n);

    assign mode = timer_pkg::chan_mode(cfg_r, cas);

    if (n < timer_pkg::NFILT) begin : g_filt
      filter_if fif (.aclk(aclk), .aresetn(aresetn));
      assign fif.sample = sync2_r;
      assign fif.tick = filt_tick;
      assign fif.fval = fval;
      glitch_filter u_filt (.f(fif));
      // zero filter value takes the plain synchroniser path
      assign filt_in = (fval == 4'h0) ? sync2_r : fif.filt;
    end else begin : g_nofilt
      assign filt_in = sync2_r;
    end

    // edge detect after the two-stage synchroniser: unfiltered flag on the third edge
    wire rise = filt_in && !prev_r;
    wire fall = !filt_in && prev_r;
    wire cap_evt = (mode == timer_pkg::MODE_CAPTURE) && ((rise && ela) || (fall && elb));
    // match as the counter steps onto the value, so a pulse spans value minus initial
    wire match = cnt_tick && (count_nxt == val_r);
    wire zero_duty = (val_r == 16'h0000) || (val_r == initial_count_r);
    wire full_duty = (val_r > final_count_r) || (val_r < initial_count_r);
    wire pwm_part = !zero_duty && !full_duty;
    wire oc_set = (mode == timer_pkg::MODE_COMPARE) && match;
    wire pwm_set = (mode == timer_pkg::MODE_EPWM) && match && pwm_part;
    wire flag_set = cap_evt || oc_set || pwm_set;
    wire drives = ((mode == timer_pkg::MODE_COMPARE) || (mode == timer_pkg::MODE_EPWM)) &&
                  (ela || elb);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_r <= timer_pkg::CFG_RST;
        val_r <= timer_pkg::CNT_RST;
      end else begin
        if (sel && !wr_is_val)
          cfg_r <= wr_word[timer_pkg::CFG_W-1:0];
        if (cap_evt)
          val_r <= count_r;
        else if (sel && wr_is_val && (mode != timer_pkg::MODE_CAPTURE))
          val_r <= wr_word[CW-1:0];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1_r <= 1'b0;
        sync2_r <= 1'b0;
        prev_r <= 1'b0;
        flag_r <= 1'b0;
      end else begin
        sync1_r <= channel_pin_in[n];
        sync2_r <= sync1_r;
        prev_r <= filt_in;
        // a new event beats a clear in the same cycle
        flag_r <= flag_set || (flag_r && !flag_clr[n]);
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_r <= 1'b0;
      end else if (mode == timer_pkg::MODE_COMPARE && match) begin
        unique case ({elb, ela})
          2'h1: out_r <= !out_r;
          2'h2: out_r <= 1'b0;
          2'h3: out_r <= 1'b1;
          default: out_r <= out_r;
        endcase
      end else if (mode == timer_pkg::MODE_EPWM && (ela || elb)) begin
        if (overflow)
          out_r <= zero_duty ? ela : !ela;
        else if (match && pwm_part)
          out_r <= ela;
      end
    end

    assign flags[n] = flag_r;
    assign cfgv[n] = cfg_r;
    assign valv[n] = val_r;
    assign channel_pin_out[n] = out_r;
    assign channel_pin_oe_n[n] = !drives;
    assign channel_irq[n] = flag_r && cfg_r[timer_pkg::CFG_IE];
  end

endmodule : timer_core

// ==== logic/timer_pkg.sv ====
// timer_pkg: shared constants, channel mode decode and register helpers
// assumes a single system clock and 32-bit register words on the bus
package timer_pkg;

  localparam int NCH = 6;
  localparam int NFILT = 4;
  localparam int CW = 16;
  localparam int AW = 12;
  localparam int CFG_W = 12;
  localparam int CTRL_W = 5;
  localparam int PSC_W = 7;
  localparam int FV_W = 4;

  // register byte offsets
  localparam logic [AW-1:0] OFF_CTRL = 12'h000;
  localparam logic [AW-1:0] OFF_COUNT = 12'h004;
  localparam logic [AW-1:0] OFF_INIT = 12'h008;
  localparam logic [AW-1:0] OFF_FINAL = 12'h00C;
  localparam logic [AW-1:0] OFF_FLAGS = 12'h010;
  // channel n: config at 0x40 + 8n, value at 0x44 + 8n
  localparam logic [5:0] CHAN_PAGE = 6'h01;
  localparam int CHAN_SEL_LSB = 3;
  localparam int CHAN_VAL_BIT = 2;

  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int CTRL_PS_W = 3;
  localparam int CTRL_CAS = 4;

  // channel config fields
  localparam int CFG_ELA = 0;
  localparam int CFG_ELB = 1;
  localparam int CFG_MSA = 2;
  localparam int CFG_MSB = 3;
  localparam int CFG_IE = 4;
  localparam int CFG_DEC = 5;
  localparam int CFG_COMB = 6;
  localparam int CFG_FV_LSB = 8;

  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam logic [CW-1:0] FINAL_RST = 16'hFFFF;

  // filter counter runs on the system clock divided by this
  localparam int FILT_DIV = 4;
  localparam logic [1:0] FILT_DIV_LAST = 2'(FILT_DIV - 1);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_IDLE, MODE_CAPTURE, MODE_COMPARE, MODE_EPWM} mode_t;

  function automatic mode_t chan_mode(input logic [CFG_W-1:0] cfg, input logic cas);
    chan_mode = MODE_IDLE;
    if (!cfg[CFG_DEC] && !cfg[CFG_COMB] && !cas) begin
      if (cfg[CFG_MSB])
        chan_mode = MODE_EPWM;
      else if (cfg[CFG_MSA])
        chan_mode = MODE_COMPARE;
      else if (cfg[CFG_ELB] || cfg[CFG_ELA])
        chan_mode = MODE_CAPTURE;
    end
  endfunction : chan_mode

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      wmerge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
  endfunction : wmerge

  function automatic logic reg_hit(input logic [AW-1:0] addr);
    logic [AW-1:0] a;
    a = {addr[AW-1:2], 2'h0};
    reg_hit = (a == OFF_CTRL) || (a == OFF_COUNT) || (a == OFF_INIT) ||
              (a == OFF_FINAL) || (a == OFF_FLAGS) ||
              ((a[AW-1:6] == CHAN_PAGE) && (int'(a[5:3]) < NCH));
  endfunction : reg_hit

  function automatic logic [31:0] reg_read(input logic [AW-1:0] addr,
                                           input logic [CTRL_W-1:0] ctrl,
                                           input logic [CW-1:0] count,
                                           input logic [CW-1:0] init,
                                           input logic [CW-1:0] fin,
                                           input logic [NCH-1:0] flags,
                                           input logic [NCH-1:0][CFG_W-1:0] cfgv,
                                           input logic [NCH-1:0][CW-1:0] valv);
    logic [2:0] idx;
    logic [AW-1:0] a;
    idx = addr[5:3];
    a = {addr[AW-1:2], 2'h0};
    reg_read = 32'h0000_0000;
    if ((a[AW-1:6] == CHAN_PAGE) && (int'(idx) < NCH))
      reg_read = a[CHAN_VAL_BIT] ? 32'(valv[idx]) : 32'(cfgv[idx]);
    else if (a == OFF_CTRL)
      reg_read = 32'(ctrl);
    else if (a == OFF_COUNT)
      reg_read = 32'(count);
    else if (a == OFF_INIT)
      reg_read = 32'(init);
    else if (a == OFF_FINAL)
      reg_read = 32'(fin);
    else if (a == OFF_FLAGS)
      reg_read = 32'(flags);
  endfunction : reg_read

endpackage : timer_pkg

// ==== verif/channel_pin_model.sv ====
// channel_pin_model: outside signals on the six channel pins
// assumes the bench sets ext_level; a pin the timer drives reads back the timer level
module channel_pin_model (
  input logic [timer_pkg::NCH-1:0] ext_level,
  input logic [timer_pkg::NCH-1:0] pin_out,
  input logic [timer_pkg::NCH-1:0] pin_oe_n,
  output logic [timer_pkg::NCH-1:0] pin_in
);
  // wire level resolved from both parties, the timer winning where it drives
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : channel_pin_model

// ==== verif/tb_timer_channel_capture_compare_epwm.sv ====
// tb_timer_channel_capture_compare_epwm: register-driven checks of capture, compare and pwm
// assumes the timer_core register map, six channels, filters on 0 to 3, prescale 1 except the closing prescale 2 count check
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
$display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module tb_timer_channel_capture_compare_epwm;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] OK = timer_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = timer_pkg::RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [timer_pkg::AW-1:0] awaddr = 12'h000;
  logic [timer_pkg::AW-1:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic debug_halt = 1'b0;
  logic [5:0] ext_level = 6'h00;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_d;
  logic [5:0] pin_in, pin_out, oe_n, irq;
  logic [15:0] cap;
  logic prev = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  int highs;
  logic [11:0] ra[7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h040, 12'h044};
  logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
  logic [1:0] cels[5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
  logic cpin[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [31:0] ei[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h3, 32'h3};
  logic [31:0] ev[7] = '{32'h4, 32'h4, 32'h0, 32'hC, 32'h3, 32'h6, 32'h2};
  logic [31:0] ec[7] = '{32'h1A, 32'h19, 32'h1A, 32'h1A, 32'h1A, 32'h1A, 32'h1A};
  int eh[7] = '{8, 12, 0, 20, 0, 6, 14};
  logic ef[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  always #20 aclk = ~aclk;

  timer_core uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .debug_halt(debug_halt),
    .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe_n(oe_n),
    .channel_irq(irq)
  );
  channel_pin_model far (.ext_level(ext_level), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_in(pin_in));

  task automatic final_report();
    $display("mismatches %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    bit done = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (n > 64) begin
        num_errors++;
        final_report();
      end
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
        done = 1;
      end
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    int n = 0;
    bit done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (n > 64) begin
        num_errors++;
        final_report();
      end
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        `CHK("rresp", er, rresp)
        rready <= 1'b0;
        done = 1;
      end
    end
  endtask : rd

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    rd(a, er, rd_d);
    `CHK("rdata", ed, rd_d)
  endtask : rd_chk

  // flag must stay clear for two edges after the pin moves and appear at the third
  task automatic edge_check(input int ch, input logic lvl, input logic exp);
    @(posedge aclk);
    ext_level[ch] <= lvl;
    repeat (2) @(posedge aclk);
    #1 `CHK("irq before third edge", 1'b0, irq[ch])
    @(posedge aclk);
    #1 `CHK("irq at third edge", exp, irq[ch])
  endtask : edge_check

  task automatic wait_irq(input int ch, input int lim);
    int n = 0;
    while (irq[ch] !== 1'b1 && n < lim) begin
      @(posedge aclk);
      #1 n++;
    end
    `CHK("irq wait", 1'b1, irq[ch])
    if (irq[ch] !== 1'b1) final_report();
  endtask : wait_irq

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], rv[i], OK);
    rd_chk(12'hFF0, 32'h0, ERR);
    wr(12'hFF0, 32'h1, ERR);
    // channel 4 has no filter, so its filter field must not add delay
    wr(12'h060, 32'hF11, OK);
    wr(12'h000, 32'h1, OK);
    repeat (37) @(posedge aclk);
    debug_halt <= 1'b1;
    rd(12'h004, OK, rd_d);
    cap = rd_d[15:0];
    edge_check(4, 1'b1, 1'b1);
    rd_chk(12'h064, {16'h0, cap}, OK);
    wr(12'h064, 32'h1234, OK);
    rd_chk(12'h064, {16'h0, cap}, OK);
    rd_chk(12'h010, 32'h10, OK);
    wr(12'h010, 32'h10, OK);
    edge_check(4, 1'b0, 1'b0);
    wr(12'h060, 32'h12, OK);
    edge_check(4, 1'b1, 1'b0);
    edge_check(4, 1'b0, 1'b1);
    // dual-edge capture, then center-aligned counting, each must stop capture
    wr(12'h010, 32'h10, OK);
    wr(12'h060, 32'h32, OK);
    edge_check(4, 1'b1, 1'b0);
    edge_check(4, 1'b0, 1'b0);
    wr(12'h060, 32'h12, OK);
    wr(12'h000, 32'h11, OK);
    edge_check(4, 1'b1, 1'b0);
    edge_check(4, 1'b0, 1'b0);
    wr(12'h000, 32'h1, OK);
    rd_chk(12'h064, {16'h0, cap}, OK);
    debug_halt <= 1'b0;
    wr(12'h010, 32'h3F, OK);
    wr(12'h040, 32'h211, OK);
    @(posedge aclk);
    ext_level[0] <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_level[0] <= 1'b0;
    repeat (24) @(posedge aclk);
    #1 `CHK("glitch passed", 1'b0, irq[0])
    @(posedge aclk);
    ext_level[0] <= 1'b1;
    repeat (8) @(posedge aclk);
    #1 `CHK("filter early", 1'b0, irq[0])
    wait_irq(0, 8);
    wr(12'h040, 32'h012, OK);
    wr(12'h010, 32'h3F, OK);
    edge_check(0, 1'b0, 1'b1);
    wr(12'h00C, 32'h9, OK);
    wr(12'h004, 32'h0, OK);
    wr(12'h04C, 32'h5, OK);
    foreach (cels[i]) begin
      wr(12'h000, 32'h0, OK);
      wr(12'h048, 32'h14 | 32'(cels[i]), OK);
      wr(12'h010, 32'h3F, OK);
      if (cels[i] != 2'h0) `CHK("held level", prev, pin_out[1])
      wr(12'h000, 32'h1, OK);
      wait_irq(1, 40);
      `CHK("pin released", cels[i] == 2'h0, oe_n[1])
      if (cels[i] != 2'h0) `CHK("compare level", cpin[i], pin_out[1])
      prev = cpin[i];
    end
    wr(12'h048, 32'h0, OK);
    foreach (ei[i]) begin
      wr(12'h008, ei[i], OK);
      wr(12'h054, ev[i], OK);
      wr(12'h050, ec[i], OK);
      wr(12'h004, 32'h0, OK);
      repeat (12) @(posedge aclk);
      wr(12'h010, 32'h3F, OK);
      highs = 0;
      repeat (2 * (10 - int'(ei[i]))) begin
        @(posedge aclk);
        #1 highs += int'(pin_out[2] === 1'b1);
      end
      `CHK("pwm high cycles", eh[i], highs)
      `CHK("pwm flag", ef[i], irq[2])
    end
    // prescale 2: four run cycles between the two control writes give two steps
    wr(12'h000, 32'h0, OK);
    wr(12'h004, 32'h0, OK);
    wr(12'h000, 32'h3, OK);
    wr(12'h000, 32'h0, OK);
    rd_chk(12'h004, 32'h5, OK);
    final_report();
  end
endmodule : tb_timer_channel_capture_compare_epwm

// ==== verif/timer_core_sva.sv ====
// timer_core_sva: bus handshake and reset-state checks on the timer top ports
// assumes one clock domain and the synchronous active-low reset
module timer_core_sva (
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  input logic awready,
  input logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  input logic bready,
  input logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic rvalid,
  input logic rready,
  input logic [timer_pkg::NCH-1:0] channel_pin_oe_n,
  input logic [timer_pkg::NCH-1:0] channel_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_both;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence

  a_write_answer: assert property (wr_both |-> ##[1:2] bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_aw_drop: assert property (awvalid && awready |=> !awready)
    else $error("second write address accepted");
  a_w_drop: assert property (wvalid && wready |=> !wready)
    else $error("second write data accepted");
  a_read_answer: assert property (rd_take |=> rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data changed before taken");
  a_read_done: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address taken during read data");
  // a fresh reset must leave every pin released and no interrupt pending
  a_reset_state: assert property ($rose(aresetn) |-> (&channel_pin_oe_n) && !(|channel_irq)
                                  && !bvalid && !rvalid)
    else $error("outputs not at reset state");
endmodule : timer_core_sva

bind timer_core timer_core_sva chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .channel_pin_oe_n(channel_pin_oe_n), .channel_irq(channel_irq)
);
